// file: hdl/bmca_host.sv
// host side of the memory cycle arbiter: external memory access unit plus one channel terminal
//
// Contract
// - peripheral answers a grant within 300 ns.
// - max-rate line raised by first transfer request, held while fast.
// - max-rate line dropped when the block completes.
// - memory request held at least 2 us, shorter than following cycle.
// - output mode: unit raises transfer-complete after capturing the word.
// - input mode: unit drives data on memory-available, releases on complete.
// - address and direction presented together with the memory request.
// - external unit itself detects and handles protect violations.
// - terminal requests when input buffer loaded or output register emptied.
// - terminal drives data-accepted and data-here alongside transfer request; here data-here rises as the request drops, data-accepted a cycle later.
`timescale 1ns/100ps
`default_nettype none
module bmca_host import bmca_pkg::*; #(
	parameter int BURST_W = CNT_W
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// access commands
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire bmca_cmd_s cmd,
	input wire bmca_addr_t prot_base,
	output logic rsp_valid,
	output bmca_rsp_s rsp,
	// terminal user side
	input wire logic term_start,
	input wire logic term_dir,
	input wire logic [BLK_W-1:0] term_len,
	input wire logic term_max_rate,
	output logic term_busy,
	input wire logic term_wr_valid,
	output logic term_wr_ready,
	input wire bmca_word_t term_wr_data,
	output logic term_rd_valid,
	input wire logic term_rd_ready,
	output bmca_word_t term_rd_data,
	// external access cable
	input wire logic ext_mem_avail,
	input wire logic ext_xfer_done_in,
	output logic ext_mem_req,
	output bmca_addr_t ext_addr,
	output logic ext_dir,
	output logic ext_xfer_done_out,
	// channel cable
	input wire logic ch_grant,
	output logic ch_dtr,
	output logic ch_max_rate,
	output logic ch_data_accepted,
	output logic ch_data_here,
	// shared io bus
	input wire bmca_word_t io_data_in,
	output bmca_word_t io_data_out,
	output logic io_data_oe
);
	initial begin
		if (BURST_W != CNT_W) $error("burst width must match package");
		if (REQ_MIN_CYC >= (1 << MIN_W)) $error("minimum request count does not fit");
	end

	bmca_xreg_s r, n;
	logic av_rise;
	logic prot_hit;
	logic finish;
	logic min_done;
	bmca_word_t t_out;
	logic t_oe;

	assign av_rise = r.av2 & ~r.av3;
	assign min_done = r.min_cnt >= REQ_MIN_CNT;
	// unit itself refuses writes into the protected area below prot_base
	assign prot_hit = (cmd.dir == DIR_IN) && (cmd.addr < prot_base);

	always_comb begin
		n = r;
		finish = 1'b0;
		n.rsp_v = 1'b0;
		n.av1 = ext_mem_avail;
		n.av2 = r.av1;
		n.av3 = r.av2;
		n.dn1 = ext_xfer_done_in;
		n.dn2 = r.dn1;
		n.io1 = io_data_in;
		n.io2 = r.io1;
		if (r.req && !min_done)
			n.min_cnt = MIN_W'(r.min_cnt + 1'b1);
		case (r.st)
			X_IDLE: begin
				if (cmd_valid && !r.req) begin
					if (prot_hit) begin
						n.rsp_v = 1'b1;
						n.rsp.err = 1'b1;
						n.rsp.data = '0;
					end else begin
						n.req = 1'b1;
						n.addr = cmd.addr;
						n.dir = cmd.dir;
						n.wdata = cmd.data;
						n.left = (cmd.len == '0) ? CNT_W'(1) : cmd.len;
						n.min_cnt = '0;
						n.last_gnt = 1'b0;
						n.st = X_REQ;
					end
				end
			end
			X_REQ: begin
				if (av_rise) begin
					n.last_gnt = (r.left == CNT_W'(1));
					if (r.dir == DIR_OUT) begin
						n.st = X_CAPT;
					end else begin
						n.oe = 1'b1;
						n.st = X_DRIVE;
					end
				end
			end
			X_CAPT: begin
				// word has stood through two sync stages, take it and acknowledge
				n.rsp.data = r.io2;
				n.done_out = 1'b1;
				n.st = X_ACK;
			end
			X_ACK: begin
				if (!r.av2) begin
					n.done_out = 1'b0;
					finish = 1'b1;
				end
			end
			X_DRIVE: begin
				if (r.dn2) begin
					n.oe = 1'b0;
					n.rsp.data = r.wdata;
					finish = 1'b1;
				end
			end
			default: n.st = X_IDLE;
		endcase
		if (finish) begin
			n.rsp_v = 1'b1;
			n.rsp.err = 1'b0;
			if (r.left == CNT_W'(1)) begin
				n.st = X_IDLE;
			end else begin
				n.left = CNT_W'(r.left - 1'b1);
				n.addr = ADDR_W'(r.addr + 1'b1);
				n.st = X_REQ;
			end
		end
		// drop the request once the last cycle is granted and 2 us have passed
		if (r.req && r.last_gnt && min_done) begin
			n.req = 1'b0;
			n.last_gnt = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			r <= '0;
		else
			r <= n;
	end

	bmca_term #(
		.BLK_LEN_W(BLK_W)
	) u_term (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.start(term_start),
		.start_dir(term_dir),
		.start_len(term_len),
		.max_rate_en(term_max_rate),
		.busy(term_busy),
		.wr_valid(term_wr_valid),
		.wr_ready(term_wr_ready),
		.wr_data(term_wr_data),
		.rd_valid(term_rd_valid),
		.rd_ready(term_rd_ready),
		.rd_data(term_rd_data),
		.ch_grant(ch_grant),
		.ch_dtr(ch_dtr),
		.ch_max_rate(ch_max_rate),
		.ch_data_accepted(ch_data_accepted),
		.ch_data_here(ch_data_here),
		.io_in(io_data_in),
		.io_out(t_out),
		.io_oe(t_oe)
	);

	assign cmd_ready = (r.st == X_IDLE) && !r.req;
	assign rsp_valid = r.rsp_v;
	assign rsp = r.rsp;
	assign ext_mem_req = r.req;
	assign ext_addr = r.addr;
	assign ext_dir = r.dir;
	assign ext_xfer_done_out = r.done_out;
	assign io_data_oe = r.oe | t_oe;
	assign io_data_out = r.oe ? r.wdata : t_out;

	property p_req_min;
		@(posedge core_clk) disable iff (!rst_n)
		$fell(ext_mem_req) |-> $past(r.min_cnt) >= REQ_MIN_CNT;
	endproperty
	a_req_min: assert property (p_req_min) else $error("memory request shorter than minimum");

	property p_req_short;
		@(posedge core_clk) disable iff (!rst_n)
		(r.req && r.last_gnt && min_done) |=> !ext_mem_req;
	endproperty
	a_req_short: assert property (p_req_short) else $error("memory request held past last grant");

	property p_addr_with_req;
		@(posedge core_clk) disable iff (!rst_n)
		$rose(ext_mem_req) |-> ext_addr == $past(cmd.addr) && ext_dir == $past(cmd.dir);
	endproperty
	a_addr_with_req: assert property (p_addr_with_req) else $error("address or direction not with request");

	property p_done_after_capt;
		@(posedge core_clk) disable iff (!rst_n)
		$rose(ext_xfer_done_out) |-> ext_dir == DIR_OUT && rsp.data == $past(r.io2);
	endproperty
	a_done_after_capt: assert property (p_done_after_capt) else $error("complete raised without captured word");

	property p_done_hold;
		@(posedge core_clk) disable iff (!rst_n)
		$rose(ext_xfer_done_out) |-> ext_xfer_done_out throughout (r.av2 [*1]);
	endproperty
	a_done_hold: assert property (p_done_hold) else $error("complete dropped while memory still available");

	property p_drive_on_avail;
		@(posedge core_clk) disable iff (!rst_n)
		(r.st == X_REQ && av_rise && r.dir == DIR_IN) |=> io_data_oe && io_data_out == r.wdata;
	endproperty
	a_drive_on_avail: assert property (p_drive_on_avail) else $error("input word not driven on memory available");

	property p_release_on_done;
		@(posedge core_clk) disable iff (!rst_n)
		(r.st == X_DRIVE && r.dn2) |=> !r.oe ##1 !r.oe;
	endproperty
	a_release_on_done: assert property (p_release_on_done) else $error("bus not released after complete");

	property p_protect;
		@(posedge core_clk) disable iff (!rst_n)
		(cmd_ready && cmd_valid && prot_hit) |=> !ext_mem_req && rsp_valid && rsp.err;
	endproperty
	a_protect: assert property (p_protect) else $error("protected write not refused");

	property p_bus_single;
		@(posedge core_clk) disable iff (!rst_n)
		!(r.oe && t_oe);
	endproperty
	a_bus_single: assert property (p_bus_single) else $error("two drivers on the io bus");

	property p_done_fall;
		@(posedge core_clk) disable iff (!rst_n)
		$fell(ext_xfer_done_out) |-> !$past(r.av2);
	endproperty
	a_done_fall: assert property (p_done_fall) else $error("complete dropped before memory available fell");

	property p_release_only_done;
		@(posedge core_clk) disable iff (!rst_n)
		$fell(r.oe) |-> $past(r.dn2);
	endproperty
	a_release_only_done: assert property (p_release_only_done) else $error("bus released before complete");

	property p_addr_hold;
		@(posedge core_clk) disable iff (!rst_n)
		(ext_mem_req && !finish) |=> $stable(ext_addr) && $stable(ext_dir);
	endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("address or direction moved under request");

	property p_burst_addr;
		@(posedge core_clk) disable iff (!rst_n)
		(finish && r.left != CNT_W'(1)) |=> ext_addr == ADDR_W'($past(ext_addr) + 1'b1);
	endproperty
	a_burst_addr: assert property (p_burst_addr) else $error("burst address did not step by one");

	property p_term_here;
		@(posedge core_clk) disable iff (!rst_n)
		t_oe |-> ch_data_here;
	endproperty
	a_term_here: assert property (p_term_here) else $error("terminal drives bus without data here");

	c_ext_out: cover property (@(posedge core_clk) disable iff (!rst_n) $fell(ext_xfer_done_out));
	c_ext_in: cover property (@(posedge core_clk) disable iff (!rst_n) $fell(r.oe) && rsp_valid);
	c_ext_burst: cover property (@(posedge core_clk) disable iff (!rst_n) finish && r.left == CNT_W'(2));
endmodule : bmca_host
`default_nettype wire

// file: hdl/bmca_pkg.sv
// shared constants, types and state records for the memory cycle arbiter host side
package bmca_pkg;
	// word, address and count widths
	localparam int DATA_W = 16;
	localparam int ADDR_W = 15;
	localparam int CNT_W = 8;
	localparam int BLK_W = 16;
	localparam int MIN_W = 8;

	// timing, clock at 100 MHz
	localparam int CLK_PERIOD_NS = 10;
	localparam int RESP_TIME_NS = 300;
	localparam int RESP_CYC = RESP_TIME_NS / CLK_PERIOD_NS;
	localparam int REQ_MIN_NS = 2000;
	localparam int REQ_MIN_CYC = (REQ_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MEM_CYCLE_NS = 1750;
	localparam int MEM_CYCLE_CYC = MEM_CYCLE_NS / CLK_PERIOD_NS;
	localparam logic [MIN_W-1:0] REQ_MIN_CNT = MIN_W'(REQ_MIN_CYC);

	// transfer direction on the access cable and channel
	localparam logic DIR_OUT = 1'b0;
	localparam logic DIR_IN = 1'b1;

	typedef logic [DATA_W-1:0] bmca_word_t;
	typedef logic [ADDR_W-1:0] bmca_addr_t;

	typedef enum logic [2:0] {
		X_IDLE = 3'h0,
		X_REQ = 3'h1,
		X_CAPT = 3'h2,
		X_ACK = 3'h3,
		X_DRIVE = 3'h4
	} bmca_xst_e;

	typedef enum logic [1:0] {
		T_IDLE = 2'h0,
		T_RUN = 2'h1,
		T_CONN = 2'h2
	} bmca_tst_e;

	typedef struct packed {
		logic dir;
		bmca_addr_t addr;
		bmca_word_t data;
		logic [CNT_W-1:0] len;
	} bmca_cmd_s;

	typedef struct packed {
		logic err;
		bmca_word_t data;
	} bmca_rsp_s;

	typedef struct packed {
		bmca_xst_e st;
		logic req;
		bmca_addr_t addr;
		logic dir;
		bmca_word_t wdata;
		logic [CNT_W-1:0] left;
		logic oe;
		logic done_out;
		logic last_gnt;
		logic [MIN_W-1:0] min_cnt;
		logic av1;
		logic av2;
		logic av3;
		logic dn1;
		logic dn2;
		bmca_word_t io1;
		bmca_word_t io2;
		logic rsp_v;
		bmca_rsp_s rsp;
	} bmca_xreg_s;

	typedef struct packed {
		bmca_tst_e st;
		logic dir;
		logic [BLK_W-1:0] left;
		bmca_word_t buf_w;
		logic buf_full;
		logic cap_pend;
		logic max_r;
		logic dtr;
		logic oe;
		logic here;
		logic accepted;
		logic g1;
		logic g2;
		logic g3;
		bmca_word_t io1;
		bmca_word_t io2;
	} bmca_treg_s;
endpackage : bmca_pkg

// file: hdl/bmca_term.sv
// peripheral data terminal facing one block transfer channel
`timescale 1ns/100ps
`default_nettype none
module bmca_term import bmca_pkg::*; #(
	parameter int BLK_LEN_W = BLK_W
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// user control
	input wire logic start,
	input wire logic start_dir,
	input wire logic [BLK_W-1:0] start_len,
	input wire logic max_rate_en,
	output logic busy,
	// user words toward memory
	input wire logic wr_valid,
	output logic wr_ready,
	input wire bmca_word_t wr_data,
	// user words from memory
	output logic rd_valid,
	input wire logic rd_ready,
	output bmca_word_t rd_data,
	// channel cable
	input wire logic ch_grant,
	output logic ch_dtr,
	output logic ch_max_rate,
	output logic ch_data_accepted,
	output logic ch_data_here,
	// io bus share
	input wire bmca_word_t io_in,
	output bmca_word_t io_out,
	output logic io_oe
);
	initial begin
		if (BLK_LEN_W != BLK_W) $error("block length width must match package");
	end

	bmca_treg_s r, n;
	logic g_rise;
	logic g_fall;

	assign g_rise = r.g2 & ~r.g3;
	assign g_fall = ~r.g2 & r.g3;

	always_comb begin
		n = r;
		n.g1 = ch_grant;
		n.g2 = r.g1;
		n.g3 = r.g2;
		n.io1 = io_in;
		n.io2 = r.io1;
		if (rd_ready && r.buf_full && r.dir == DIR_OUT)
			n.buf_full = 1'b0;
		if (wr_valid && !r.buf_full && r.dir == DIR_IN && r.st == T_RUN) begin
			n.buf_w = wr_data;
			n.buf_full = 1'b1;
		end
		case (r.st)
			T_IDLE: begin
				if (start && !r.buf_full && start_len != '0) begin
					n.dir = start_dir;
					n.left = start_len;
					n.max_r = max_rate_en;
					n.st = T_RUN;
				end
			end
			T_RUN: begin
				if (g_rise && r.dtr) begin
					n.st = T_CONN;
					if (r.dir == DIR_IN) begin
						n.oe = 1'b1;
						n.here = 1'b1;
					end else begin
						n.cap_pend = 1'b1;
					end
				end
			end
			T_CONN: begin
				if (r.cap_pend) begin
					n.buf_w = r.io2;
					n.buf_full = 1'b1;
					n.accepted = 1'b1;
					n.cap_pend = 1'b0;
				end
				if (g_fall && !r.cap_pend) begin
					n.oe = 1'b0;
					n.here = 1'b0;
					n.accepted = 1'b0;
					if (r.dir == DIR_IN)
						n.buf_full = 1'b0;
					n.left = BLK_W'(r.left - 1'b1);
					if (r.left == BLK_W'(1)) begin
						n.max_r = 1'b0;
						n.st = T_IDLE;
					end else begin
						n.st = T_RUN;
					end
				end
			end
			default: n.st = T_IDLE;
		endcase
		// request when input buffer loaded or output register emptied
		n.dtr = (n.st == T_RUN) && (n.dir == DIR_IN ? n.buf_full : !n.buf_full);
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			r <= '0;
		else
			r <= n;
	end

	assign busy = (r.st != T_IDLE) || r.buf_full;
	assign wr_ready = (r.st == T_RUN) && r.dir == DIR_IN && !r.buf_full;
	assign rd_valid = r.buf_full && r.dir == DIR_OUT;
	assign rd_data = r.buf_w;
	assign ch_dtr = r.dtr;
	assign ch_max_rate = r.max_r;
	assign ch_data_accepted = r.accepted;
	assign ch_data_here = r.here;
	assign io_out = r.buf_w;
	assign io_oe = r.oe;

	property p_resp_time;
		@(posedge core_clk) disable iff (!rst_n)
		(r.st == T_RUN && g_rise && r.dtr) |-> ##[1:3] (io_oe || ch_data_accepted);
	endproperty
	a_resp_time: assert property (p_resp_time) else $error("no response to grant in time");

	property p_max_first;
		@(posedge core_clk) disable iff (!rst_n)
		(r.st == T_IDLE && start && !r.buf_full && start_len != '0 && max_rate_en) |=> ch_max_rate && !ch_dtr;
	endproperty
	a_max_first: assert property (p_max_first) else $error("max rate not raised before first request");

	property p_max_drop;
		@(posedge core_clk) disable iff (!rst_n)
		(r.st == T_CONN && g_fall && !r.cap_pend && r.left == BLK_W'(1)) |=> !ch_max_rate ##1 !ch_max_rate;
	endproperty
	a_max_drop: assert property (p_max_drop) else $error("max rate held after block end");

	property p_dtr_ready;
		@(posedge core_clk) disable iff (!rst_n)
		ch_dtr |-> (r.dir == DIR_IN) ? r.buf_full : !r.buf_full;
	endproperty
	a_dtr_ready: assert property (p_dtr_ready) else $error("transfer request without ready data");

	property p_here_drive;
		@(posedge core_clk) disable iff (!rst_n)
		$rose(ch_data_here) |-> io_oe && r.dir == DIR_IN && io_out == $past(r.buf_w);
	endproperty
	a_here_drive: assert property (p_here_drive) else $error("data here without driven word");

	property p_accept_full;
		@(posedge core_clk) disable iff (!rst_n)
		$rose(ch_data_accepted) |-> r.dir == DIR_OUT && rd_valid && !io_oe;
	endproperty
	a_accept_full: assert property (p_accept_full) else $error("data accepted without captured word");

	c_term_in: cover property (@(posedge core_clk) disable iff (!rst_n) $fell(ch_data_here));
	c_term_out: cover property (@(posedge core_clk) disable iff (!rst_n) $fell(ch_data_accepted) && ch_max_rate);
endmodule : bmca_term
`default_nettype wire

// file: test/bmca_mem_model.sv
// arbiter and core memory model facing the host side cable and channel
`timescale 1ns/100ps
`default_nettype none
module bmca_mem_model import bmca_pkg::*; (
	// clock and bench control
	input wire logic core_clk,
	input wire logic inhibit,
	// external access cable
	input wire logic ext_mem_req,
	input wire bmca_addr_t ext_addr,
	input wire logic ext_dir,
	input wire logic ext_xfer_done_out,
	output logic ext_mem_avail,
	output logic ext_xfer_done_in,
	// channel cable
	input wire logic ch_dtr,
	input wire logic ch_max_rate,
	input wire logic ch_data_accepted,
	input wire logic ch_data_here,
	output logic ch_grant,
	// io bus
	input wire bmca_word_t io_data_out,
	input wire logic io_data_oe,
	output bmca_word_t drv_data
);
	bmca_word_t mem [bmca_addr_t];
	bmca_word_t ch_q [$];
	bmca_word_t ch_n;
	int k;

	task automatic tick(int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : tick

	initial begin
		ext_mem_avail = 1'b0;
		ext_xfer_done_in = 1'b0;
		ch_grant = 1'b0;
		drv_data = 16'h5a5a;
		ch_n = 16'h3c00;
		forever begin
			tick(1);
			// stealing waits while an instruction holds it off, resumes between
			while (inhibit) tick(1);
			k = 0;
			if (ch_dtr) begin
				ch_grant = 1'b1;
				drv_data = ch_n;
				while (!ch_data_here && !ch_data_accepted && k < 40) begin
					tick(1);
					k++;
				end
				if (ch_data_here) ch_q.push_back(io_data_out);
				if (ch_data_accepted) ch_n++;
				ch_grant = 1'b0;
				drv_data = ~drv_data;
				tick(ch_max_rate ? MEM_CYCLE_CYC : 2 * MEM_CYCLE_CYC);
			end else if (ext_mem_req) begin
				ext_mem_avail = 1'b1;
				if (ext_dir == DIR_OUT) begin
					drv_data = mem.exists(ext_addr) ? mem[ext_addr] : 16'(ext_addr) ^ 16'ha5a5;
					while (!ext_xfer_done_out && k < 40) begin
						tick(1);
						k++;
					end
				end else begin
					while (!io_data_oe && k < 40) begin
						tick(1);
						k++;
					end
					if (io_data_oe) begin
						mem[ext_addr] = io_data_out;
						ext_xfer_done_in = 1'b1;
					end
					while (io_data_oe && k < 80) begin
						tick(1);
						k++;
					end
					ext_xfer_done_in = 1'b0;
				end
				ext_mem_avail = 1'b0;
				drv_data = ~drv_data;
				tick(MEM_CYCLE_CYC);
			end
		end
	end
endmodule : bmca_mem_model
`default_nettype wire

// file: test/testbench.sv
// self-checking bench for the host side of the memory cycle arbiter
`timescale 1ns/100ps
`default_nettype none
module testbench import bmca_pkg::*;;
	logic core_clk = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, inhibit = 1'b0;
	bmca_cmd_s cmd = '0;
	bmca_addr_t prot_base = 15'h0100;
	logic term_start = 1'b0, term_dir = 1'b0, term_max_rate = 1'b0;
	logic [BLK_W-1:0] term_len = '0;
	logic term_wr_valid = 1'b0, term_rd_ready = 1'b0;
	bmca_word_t term_wr_data = '0;
	logic cmd_ready, rsp_valid, term_busy, term_wr_ready, term_rd_valid, ext_mem_avail, ext_xfer_done_in;
	logic ext_mem_req, ext_dir, ext_xfer_done_out, ch_grant, ch_dtr, ch_max_rate, ch_data_accepted;
	logic ch_data_here, io_data_oe;
	bmca_rsp_s rsp;
	bmca_word_t term_rd_data, io_data_in, io_data_out, drv_data;
	bmca_addr_t ext_addr;
	int num_errors = 0, n_compared = 0;
	int req_hi = 0;

	always #5 core_clk = ~core_clk;
	assign io_data_in = io_data_oe ? io_data_out : drv_data;
	// edges at which the memory request has stood high in its current run
	always @(posedge core_clk) req_hi <= ext_mem_req ? req_hi + 1 : 0;

	bmca_host dut (.core_clk(core_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
		.prot_base(prot_base), .rsp_valid(rsp_valid), .rsp(rsp), .term_start(term_start), .term_dir(term_dir),
		.term_len(term_len), .term_max_rate(term_max_rate), .term_busy(term_busy), .term_wr_valid(term_wr_valid),
		.term_wr_ready(term_wr_ready), .term_wr_data(term_wr_data), .term_rd_valid(term_rd_valid),
		.term_rd_ready(term_rd_ready), .term_rd_data(term_rd_data), .ext_mem_avail(ext_mem_avail),
		.ext_xfer_done_in(ext_xfer_done_in), .ext_mem_req(ext_mem_req), .ext_addr(ext_addr), .ext_dir(ext_dir),
		.ext_xfer_done_out(ext_xfer_done_out), .ch_grant(ch_grant), .ch_dtr(ch_dtr), .ch_max_rate(ch_max_rate),
		.ch_data_accepted(ch_data_accepted), .ch_data_here(ch_data_here), .io_data_in(io_data_in),
		.io_data_out(io_data_out), .io_data_oe(io_data_oe));

	bmca_mem_model model (.core_clk(core_clk), .inhibit(inhibit), .ext_mem_req(ext_mem_req), .ext_addr(ext_addr),
		.ext_dir(ext_dir), .ext_xfer_done_out(ext_xfer_done_out), .ext_mem_avail(ext_mem_avail),
		.ext_xfer_done_in(ext_xfer_done_in), .ch_dtr(ch_dtr), .ch_max_rate(ch_max_rate),
		.ch_data_accepted(ch_data_accepted), .ch_data_here(ch_data_here), .ch_grant(ch_grant),
		.io_data_out(io_data_out), .io_data_oe(io_data_oe), .drv_data(drv_data));

	task automatic results();
		if (num_errors == 0 && n_compared > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : results

	task automatic step(int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : step

	task automatic chk_w(string what, bmca_word_t exp, bmca_word_t got);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : chk_w

	task automatic chk_b(string what, logic exp, logic got);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %b seen %b", what, exp, got);
		end
	endtask : chk_b

	// wait on a level, bounded
	task automatic wait_lvl(ref logic s, input logic v, input int lim);
		int k;
		k = 0;
		while (s !== v && k < lim) begin
			step(1);
			k++;
		end
	endtask : wait_lvl

	task automatic ext_cmd(logic d, bmca_addr_t a, bmca_word_t w, logic [CNT_W-1:0] n);
		wait_lvl(cmd_ready, 1'b1, 1000);
		cmd_valid = 1'b1;
		cmd = '{dir: d, addr: a, data: w, len: n};
		step(1);
		cmd_valid = 1'b0;
	endtask : ext_cmd

	task automatic wait_rsp(logic err);
		wait_lvl(rsp_valid, 1'b1, 1000);
		chk_b("rsp_valid", 1'b1, rsp_valid);
		chk_b("rsp.err", err, rsp.err);
		step(1);
	endtask : wait_rsp

	task automatic t_ext_read();
		ext_cmd(DIR_OUT, 15'h0010, 16'h0000, 8'h02);
		chk_b("ext_mem_req", 1'b1, ext_mem_req);
		chk_w("ext_addr", 16'h0010, 16'(ext_addr));
		chk_b("ext_dir", DIR_OUT, ext_dir);
		for (int i = 0; i < 2; i++) begin
			wait_rsp(1'b0);
			chk_w("read word", 16'(15'h0010 + i) ^ 16'ha5a5, rsp.data);
		end
	endtask : t_ext_read

	task automatic t_ext_write();
		ext_cmd(DIR_IN, 15'h0100, 16'hbeef, 8'h03);
		chk_b("ext_dir", DIR_IN, ext_dir);
		for (int i = 0; i < 3; i++) begin
			wait_rsp(1'b0);
			chk_b("io_data_oe", 1'b0, io_data_oe);
			chk_w("stored word", 16'hbeef, model.mem[15'h0100 + 15'(i)]);
		end
		ext_cmd(DIR_OUT, 15'h0101, 16'h0000, 8'h00);
		wait_rsp(1'b0);
		chk_w("read back", 16'hbeef, rsp.data);
		wait_lvl(ext_mem_req, 1'b0, 1000);
		chk_b("ext_mem_req held", 1'b1, req_hi >= REQ_MIN_CYC);
	endtask : t_ext_write

	task automatic t_refuse();
		ext_cmd(DIR_IN, 15'h00ff, 16'h1234, 8'h01);
		wait_rsp(1'b1);
		chk_b("ext_mem_req", 1'b0, ext_mem_req);
	endtask : t_refuse

	task automatic term_go(logic d, logic [BLK_W-1:0] n, logic m);
		term_start = 1'b1;
		term_dir = d;
		term_len = n;
		term_max_rate = m;
		step(1);
		term_start = 1'b0;
		step(1);
	endtask : term_go

	task automatic push(bmca_word_t w);
		term_wr_valid = 1'b1;
		term_wr_data = w;
		wait_lvl(term_wr_ready, 1'b1, 2000);
		step(1);
		term_wr_valid = 1'b0;
		step(1);
	endtask : push

	task automatic pop(bmca_word_t exp);
		term_rd_ready = 1'b1;
		wait_lvl(term_rd_valid, 1'b1, 2000);
		chk_w("channel word out", exp, term_rd_data);
		step(1);
		term_rd_ready = 1'b0;
		step(1);
	endtask : pop

	task automatic t_term_in();
		term_go(DIR_IN, 16'h0003, 1'b1);
		chk_b("ch_max_rate", 1'b1, ch_max_rate);
		inhibit = 1'b1;
		push(16'h7001);
		step(100);
		chk_b("ch_dtr pending", 1'b1, ch_dtr);
		inhibit = 1'b0;
		push(16'h7002);
		push(16'h7003);
		wait_lvl(term_busy, 1'b0, 3000);
		chk_b("ch_max_rate", 1'b0, ch_max_rate);
		chk_w("words moved", 16'h0003, 16'(model.ch_q.size()));
		for (int i = 0; i < 3 && i < model.ch_q.size(); i++) chk_w("channel word in", 16'h7001 + 16'(i), model.ch_q[i]);
	endtask : t_term_in

	task automatic t_term_out();
		term_go(DIR_OUT, 16'h0002, 1'b0);
		chk_b("ch_max_rate", 1'b0, ch_max_rate);
		step(400);
		chk_b("ch_dtr full", 1'b0, ch_dtr);
		pop(16'h3c00);
		pop(16'h3c01);
		wait_lvl(term_busy, 1'b0, 3000);
		chk_b("term_busy", 1'b0, term_busy);
	endtask : t_term_out

	initial begin
		repeat (50000) @(posedge core_clk);
		num_errors++;
		results();
	end

	initial begin
		step(16);
		rst_n = 1'b1;
		step(1);
		chk_b("cmd_ready", 1'b1, cmd_ready);
		chk_b("ext_mem_req", 1'b0, ext_mem_req);
		chk_b("io_data_oe", 1'b0, io_data_oe);
		chk_b("ch_dtr", 1'b0, ch_dtr);
		t_ext_read();
		t_ext_write();
		t_refuse();
		t_term_in();
		t_term_out();
		results();
	end
endmodule : testbench
`default_nettype wire
